// *** asis_top.sv ***
module asis_top (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SEQ_START,
    input wire logic CONV_DONE,
    output logic CONV_REQ,
    output logic [3:0] CONV_CHANNEL,
    output logic SEQ_BUSY
);
    // ==========================================
    // register file
    logic [31:0] sel_q, sel_d;
    logic [31:0] ctl_q, ctl_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_en, rd_en, hit_sel, hit_ctl;

    function automatic logic [2:0] step_sel(input logic [31:0] r, input logic [2:0] s);
        step_sel = r[s*asis_pkg::SEL_STRIDE +: asis_pkg::SEL_WIDTH];
    endfunction

    assign hit_sel = PADDR == asis_pkg::INPUT_SELECT_OFFSET;
    assign hit_ctl = PADDR == asis_pkg::STEP_CONTROL_OFFSET;
    assign wr_en = PSEL && PENABLE && PWRITE;
    // read data is latched in the setup cycle so it stands through the access phase
    assign rd_en = PSEL && !PENABLE && !PWRITE;
    // no wait states: every access completes in its first access cycle
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !hit_sel && !hit_ctl;
    assign PRDATA = rdata_q;

    always_comb
    begin
        sel_d = sel_q;
        ctl_d = ctl_q;
        rdata_d = rdata_q;
        if (wr_en && hit_sel)
        begin
            sel_d = PWDATA & asis_pkg::INPUT_SELECT_RW_MASK;
        end
        if (wr_en && hit_ctl)
        begin
            ctl_d = PWDATA;
        end
        if (rd_en)
        begin
            rdata_d = hit_sel ? sel_q : (hit_ctl ? ctl_q : 32'h00000000);
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            sel_q <= asis_pkg::INPUT_SELECT_RESET;
            ctl_q <= asis_pkg::STEP_CONTROL_RESET;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            sel_q <= sel_d;
            ctl_q <= ctl_d;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================
    // sequencer: one step per converter handshake
    typedef enum logic [1:0] {S_IDLE, S_REQ, S_WAIT} asis_state_e;
    asis_state_e st_q, st_d;
    logic [2:0] step_q, step_d;
    asis_pkg::asis_conv_s cur;
    logic [3:0] nib;

    // the step's nibble in the control register: bit 1 end, bit 3 temperature
    assign nib = ctl_q[step_q*asis_pkg::SEL_STRIDE +: asis_pkg::SEL_STRIDE];

    always_comb
    begin
        cur.valid = st_q == S_REQ;
        cur.temp_sensor = nib[asis_pkg::CTL_TEMP_POS];
        cur.pin = step_sel(sel_q, step_q);
    end

    always_comb
    begin
        st_d = st_q;
        step_d = step_q;
        unique case (st_q)
            S_IDLE:
            begin
                if (SEQ_START)
                begin
                    st_d = S_REQ;
                    step_d = 3'h0;
                end
            end
            S_REQ:
            begin
                st_d = S_WAIT;
            end
            S_WAIT:
            begin
                if (CONV_DONE)
                begin
                    // stop at end flag or after step eight
                    if (nib[asis_pkg::CTL_END_POS] || step_q == 3'h7)
                    begin
                        st_d = S_IDLE;
                    end
                    else
                    begin
                        st_d = S_REQ;
                        step_d = step_q + 3'h1;
                    end
                end
            end
            default:
            begin
                // the spare state code can only come from an upset; recover to idle
                st_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            st_q <= S_IDLE;
            step_q <= 3'h0;
            CONV_CHANNEL <= 4'h0;
        end
        else
        begin
            st_q <= st_d;
            step_q <= step_d;
            // latched once per step so register writes mid-step cannot move the channel
            if (cur.valid)
            begin
                // sensor overrides the pin field
                CONV_CHANNEL <= cur.temp_sensor ? asis_pkg::TEMP_SENSOR_CHANNEL
                                                : {1'b0, cur.pin};
            end
        end
    end

    assign CONV_REQ = st_q == S_WAIT;
    assign SEQ_BUSY = st_q != S_IDLE;

    // ==========================================
    // checks
    property p_reserved_zero;
        @(posedge MCLK) disable iff (RST) (sel_q & ~asis_pkg::INPUT_SELECT_RW_MASK) == 32'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_first_step;
        @(posedge MCLK) disable iff (RST)
            (st_q == S_IDLE && SEQ_START) |=> ##1 (CONV_REQ && step_q == 3'h0);
    endproperty
    a_first_step: assert property (p_first_step) else $error("first step wrong");

    property p_pin_route;
        @(posedge MCLK) disable iff (RST)
            (cur.valid && !cur.temp_sensor) |=> CONV_CHANNEL == {1'b0, $past(cur.pin)};
    endproperty
    a_pin_route: assert property (p_pin_route) else $error("pin not routed");

    property p_temp_route;
        @(posedge MCLK) disable iff (RST)
            (cur.valid && cur.temp_sensor) |=> CONV_CHANNEL == asis_pkg::TEMP_SENSOR_CHANNEL;
    endproperty
    a_temp_route: assert property (p_temp_route) else $error("sensor not routed");

    property p_end_stops;
        @(posedge MCLK) disable iff (RST)
            (st_q == S_WAIT && CONV_DONE && nib[asis_pkg::CTL_END_POS]) |=> !SEQ_BUSY;
    endproperty
    a_end_stops: assert property (p_end_stops) else $error("ran past end");

    property p_step_advance;
        @(posedge MCLK) disable iff (RST)
            (st_q == S_WAIT && CONV_DONE && !nib[asis_pkg::CTL_END_POS] && step_q != 3'h7)
                |=> (st_q == S_REQ && step_q == $past(step_q) + 3'h1);
    endproperty
    a_step_advance: assert property (p_step_advance) else $error("step not advanced");

    property p_req_holds;
        @(posedge MCLK) disable iff (RST)
            (CONV_REQ && !CONV_DONE) |=> (CONV_REQ && $stable(CONV_CHANNEL));
    endproperty
    a_req_holds: assert property (p_req_holds) else $error("request dropped early");

    property p_sel_write;
        @(posedge MCLK) disable iff (RST)
            (wr_en && hit_sel) |=> sel_q == ($past(PWDATA) & asis_pkg::INPUT_SELECT_RW_MASK);
    endproperty
    a_sel_write: assert property (p_sel_write) else $error("select write lost");

    property p_sel_read;
        @(posedge MCLK) disable iff (RST)
            (rd_en && hit_sel) |=> PRDATA == $past(sel_q);
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("select read wrong");
endmodule // asis_top

// *** asis_pkg.sv ***
package asis_pkg;
    // ==========================================
    // register map
    localparam logic [11:0] INPUT_SELECT_OFFSET = 12'h040;
    localparam logic [11:0] STEP_CONTROL_OFFSET = 12'h044;
    localparam logic [31:0] INPUT_SELECT_RESET = 32'h00000000;
    localparam logic [31:0] STEP_CONTROL_RESET = 32'h00000000;
    localparam logic [31:0] INPUT_SELECT_RW_MASK = 32'h77777777;
    // ==========================================
    // field layout: one nibble per step
    localparam int STEPS = 8;
    localparam int SEL_WIDTH = 3;
    localparam int SEL_STRIDE = 4;
    localparam int CTL_END_POS = 1;
    localparam int CTL_TEMP_POS = 3;
    localparam logic [3:0] TEMP_SENSOR_CHANNEL = 4'h8;

    typedef struct packed {
        logic valid;
        logic temp_sensor;
        logic [2:0] pin;
    } asis_conv_s;
endpackage : asis_pkg

// *** asis_testbench.sv ***
module testbench;
timeunit 1ns;
timeprecision 1ps;
// ==========================================
// clock, reset and design
logic MCLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, SEQ_START = 0, CONV_DONE = 0;
logic [11:0] PADDR = 12'h000;
logic [31:0] PWDATA = 32'h00000000, PRDATA, rd, sel, ctl;
logic PREADY, PSLVERR, CONV_REQ, SEQ_BUSY, err;
logic [3:0] CONV_CHANNEL;
int n_mismatch = 0, compares = 0, seed = 32'hbcca;
int exp_q[$];
always #2 MCLK = ~MCLK;
asis_top DUT (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SEQ_START(SEQ_START), .CONV_DONE(CONV_DONE), .CONV_REQ(CONV_REQ),
    .CONV_CHANNEL(CONV_CHANNEL), .SEQ_BUSY(SEQ_BUSY));
// ==========================================
// shared tasks
task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
        n_mismatch++;
        $display("mismatch %s expected %h seen %h", what, exp, got);
    end
endtask
// apb master: request held until pready is sampled high
task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge MCLK);
    PSEL <= 1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1;
    do @(posedge MCLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
endtask
task automatic give_verdict;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
// ==========================================
// scenarios
initial
begin
    repeat (12) @(posedge MCLK);
    RST <= 0;
    apb(0, 12'h040, 0);
    chk("reset value", 32'h00000000, rd);
    for (int i = 0; i < 8; i++)
    begin
        sel = $random(seed);
        ctl = (i == 0) ? 32'h00000000 : $random(seed) & 32'hAAAAAAAA;
        apb(1, 12'h040, sel);
        apb(1, 12'h044, ctl);
        apb(0, 12'h040, 0);
        sel = sel & 32'h77777777;
        chk("input select", sel, rd);
        // model: one expected request per step, up to and including the ending step
        exp_q.delete();
        for (int s = 0; s < 8; s++)
        begin
            exp_q.push_back(32'h10 | (ctl[4*s+3] ? asis_pkg::TEMP_SENSOR_CHANNEL : sel[4*s+:3]));
            if (ctl[4*s+1])
                break;
        end
        SEQ_START <= 1;
        @(posedge MCLK);
        SEQ_START <= 0;
        while (exp_q.size() > 0)
        begin
            // bounded wait so a stuck design only costs a mismatch
            for (int k = 0; k < 20 && CONV_REQ !== 1'b1; k++)
                @(posedge MCLK);
            rd = {27'h0, CONV_REQ, CONV_CHANNEL};
            chk("channel", exp_q.pop_front(), rd);
            CONV_DONE <= 1;
            SEQ_START <= 1'($random(seed));
            @(posedge MCLK);
            CONV_DONE <= 0;
            SEQ_START <= 0;
            @(posedge MCLK);
        end
        // a start pulse while busy is ignored and no request follows the ending step
        repeat (3)
        begin
            chk("idle", 0, {SEQ_BUSY, CONV_REQ});
            @(posedge MCLK);
        end
    end
    apb(1, 12'h048, $random(seed));
    chk("unmapped error", 1, err);
    apb(0, 12'h048, 0);
    chk("unmapped read error", 1, err);
    chk("unmapped read", 0, rd);
    apb(0, 12'h040, 0);
    chk("select kept", sel, rd);
    give_verdict();
end
initial
begin
    #20000;
    n_mismatch++;
    give_verdict();
end
endmodule // testbench
